// ### rtl/psp_consts.svh
/*
 * constants of the parallel slave port: register offsets, field positions,
 * reset values and phase timing.
 * assumes it is included by bare name from rtl files of this block only.
 */
`ifndef PSP_CONSTS_SVH
`define PSP_CONSTS_SVH
// ==========================================================
// register offsets
`define PSP_OFS_PORT_D_DATA 8'h08
`define PSP_OFS_PORT_E_DATA 8'h09
`define PSP_OFS_IRQ_FLAGS1 8'h0c
`define PSP_OFS_PORT_E_CTRL 8'h89
`define PSP_OFS_IRQ_ENABLE1 8'h8c
`define PSP_OFS_ADC_PIN_CFG 8'h9f
`define PSP_OFS_PORT_D_DIR 8'h88
// ==========================================================
// field positions
`define PSP_BIT_IN_FULL 7
`define PSP_BIT_OUT_FULL 6
`define PSP_BIT_OVERRUN 5
`define PSP_BIT_SELECT 4
`define PSP_BIT_IRQ 7
// ==========================================================
// reset values
`define PSP_RST_PORT_E_CTRL 8'h07
`define PSP_RST_IRQ_FLAGS1 8'h00
`define PSP_RST_IRQ_ENABLE1 8'h00
`define PSP_RST_ADC_PIN_CFG 8'h00
`define PSP_RST_PORT_D_DIR 8'hff
// ==========================================================
// timing: four phases per instruction cycle
`define PSP_PHASES 2'h3
`endif

// ### rtl/psp_pkg.sv
/*
 * types of the host end and the bench of the parallel slave port.
 * takes nothing from psp_consts.svh; the handshake state codes are set here.
 */
package psp_pkg;
	typedef logic [7:0] psp_byte_t;
	typedef enum logic [3:0] {
		PSP_HS_IDLE = 4'h1,
		PSP_HS_WRITE = 4'h2,
		PSP_HS_READ = 4'h4,
		PSP_HS_GAP = 4'h8
	} psp_hs_e;
endpackage

// ### rtl/psp_if.sv
/*
 * pin bundle between the external bus master and the slave port.
 * assumes the bench resolves the data wire from the two enables.
 */
`timescale 1ns/1ps
interface psp_if;
	logic rd_b;
	logic wr_b;
	logic cs_b;
	logic [7:0] host_d_out;
	logic host_d_oe_b;
	logic [7:0] dev_d_out;
	logic dev_d_oe_b;
	logic [7:0] d_in;
	modport device (input rd_b, input wr_b, input cs_b, input d_in,
		output dev_d_out, output dev_d_oe_b);
	modport host (output rd_b, output wr_b, output cs_b, input d_in,
		output host_d_out, output host_d_oe_b);
endinterface

// ### rtl/psp_device.sv
/*
 * device end of the parallel slave port: byte latches, status flags,
 * interrupt flag and enable, sampled strobes and register port.
 * assumes one clock clk_sys; strobes are asynchronous to it.
 */
`timescale 1ns/1ps
`include "psp_consts.svh"
module psp_device (
	input wire logic clk_sys,
	input wire logic rst_b,
	psp_if.device pins,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic [7:0] port_e_pins_out,
	output logic irq
);
	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [7:0] din1;
		logic [7:0] din2;
		logic [1:0] phase;
		logic wr_act;
		logic rd_act;
		logic wr_done;
		logic rd_done;
		logic wr_p2;
		logic rd_p2;
		logic [7:0] in_latch;
		logic [7:0] out_latch;
		logic [7:0] port_d_direction;
		logic [2:0] port_e_latch;
		logic [2:0] port_e_dir;
		logic slave_port_select;
		logic input_full_flag;
		logic output_full_flag;
		logic input_overrun_flag;
		logic [7:0] irq_flags;
		logic [7:0] irq_enable;
		logic [7:0] adc_pin_config;
		logic [7:0] rdata;
	} psp_dev_s;

	psp_dev_s r;
	psp_dev_s next_r;
	logic cs_l;
	logic wr_l;
	logic rd_l;

	// ==========================================================
	// strobe decode from the second synchroniser stage
	assign rd_l = ~r.sync2[0];
	assign wr_l = ~r.sync2[1];
	assign cs_l = ~r.sync2[2];

	// ==========================================================
	// next-state logic
	always_comb begin
		next_r = r;
		// pins enter two flops before any decode
		next_r.sync1 = {pins.cs_b, pins.wr_b, pins.rd_b};
		next_r.sync2 = r.sync1;
		// data lines ride the same two flops, so the byte kept at the end
		// of a write is one seen while the synchronised strobe was low
		next_r.din1 = pins.d_in;
		next_r.din2 = r.din1;
		next_r.phase = r.phase + 2'h1;
		// wait for phase two, then act at phase four
		// this runs before the strobe ends so that a completion landing
		// in a phase-two cycle is kept for the next one, never dropped
		if (r.phase == 2'h1) begin
			next_r.wr_p2 = r.wr_done;
			next_r.rd_p2 = r.rd_done;
			next_r.wr_done = 1'b0;
			next_r.rd_done = 1'b0;
		end
		// write: select and store both low
		if (r.slave_port_select && cs_l && wr_l) begin
			next_r.wr_act = 1'b1;
			next_r.in_latch = r.din2;
		end else if (r.wr_act) begin
			next_r.wr_act = 1'b0;
			next_r.wr_done = 1'b1;
		end
		// read: output full clears at once
		if (r.slave_port_select && cs_l && rd_l) begin
			next_r.rd_act = 1'b1;
			next_r.output_full_flag = 1'b0;
		end else if (r.rd_act) begin
			next_r.rd_act = 1'b0;
			next_r.rd_done = 1'b1;
		end
		// firmware register writes
		if (reg_wr) begin
			case (reg_addr)
			`PSP_OFS_PORT_D_DATA: begin
				next_r.out_latch = reg_wdata;
				next_r.output_full_flag = 1'b1;
			end
			`PSP_OFS_PORT_E_DATA: next_r.port_e_latch = reg_wdata[2:0];
			`PSP_OFS_PORT_D_DIR: next_r.port_d_direction = reg_wdata;
			`PSP_OFS_PORT_E_CTRL: begin
				next_r.port_e_dir = reg_wdata[2:0];
				next_r.slave_port_select = reg_wdata[`PSP_BIT_SELECT];
				// overrun only ever cleared here
				next_r.input_overrun_flag = reg_wdata[`PSP_BIT_OVERRUN];
			end
			`PSP_OFS_IRQ_FLAGS1: next_r.irq_flags = reg_wdata;
			`PSP_OFS_IRQ_ENABLE1: next_r.irq_enable = reg_wdata;
			`PSP_OFS_ADC_PIN_CFG: next_r.adc_pin_config = reg_wdata;
			default: next_r.rdata = next_r.rdata;
			endcase
		end
		// firmware data read clears input full
		if (reg_rd && reg_addr == `PSP_OFS_PORT_D_DATA)
			next_r.input_full_flag = 1'b0;
		// phase four completion: set wins over firmware clears, mode off still clears input full
		if (r.phase == `PSP_PHASES && r.wr_p2) begin
			if (r.input_full_flag)
				next_r.input_overrun_flag = 1'b1;
			next_r.input_full_flag = 1'b1;
			next_r.irq_flags[`PSP_BIT_IRQ] = 1'b1;
			next_r.wr_p2 = 1'b0;
		end
		if (r.phase == `PSP_PHASES && r.rd_p2) begin
			next_r.irq_flags[`PSP_BIT_IRQ] = 1'b1;
			next_r.rd_p2 = 1'b0;
		end
		// mode off holds both full flags clear
		if (!next_r.slave_port_select) begin
			next_r.input_full_flag = 1'b0;
			next_r.output_full_flag = 1'b0;
		end
		// read data, one cycle after the strobe
		next_r.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
			`PSP_OFS_PORT_D_DATA: next_r.rdata = r.in_latch;
			`PSP_OFS_PORT_E_DATA: next_r.rdata = {5'h00, r.sync2};
			`PSP_OFS_PORT_D_DIR: next_r.rdata = r.port_d_direction;
			`PSP_OFS_PORT_E_CTRL: next_r.rdata = {r.input_full_flag,
				r.output_full_flag, r.input_overrun_flag,
				r.slave_port_select, 1'b0, r.port_e_dir};
			`PSP_OFS_IRQ_FLAGS1: next_r.rdata = r.irq_flags;
			`PSP_OFS_IRQ_ENABLE1: next_r.rdata = r.irq_enable;
			`PSP_OFS_ADC_PIN_CFG: next_r.rdata =
				{r.adc_pin_config[7], 3'h0, r.adc_pin_config[3:0]};
			default: next_r.rdata = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
			r.sync1 <= 3'h7;
			r.sync2 <= 3'h7;
			r.port_d_direction <= `PSP_RST_PORT_D_DIR;
			r.port_e_dir <= 3'(`PSP_RST_PORT_E_CTRL);
			r.irq_flags <= `PSP_RST_IRQ_FLAGS1;
			r.irq_enable <= `PSP_RST_IRQ_ENABLE1;
			r.adc_pin_config <= `PSP_RST_ADC_PIN_CFG;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// outputs; in slave mode the bus read decides direction
	always_comb begin
		pins.dev_d_out = r.out_latch;
		// direction register plays no part while slave
		pins.dev_d_oe_b = ~(r.slave_port_select && r.rd_act);
		if (!r.slave_port_select)
			pins.dev_d_oe_b = 1'b1;
	end
	// port E pins are strobes in slave mode, else the latch drives only pins whose direction bit is clear
	assign port_e_pins_out = {5'h00,
		r.slave_port_select ? 3'h0 : r.port_e_latch & ~r.port_e_dir};
	assign reg_rdata = r.rdata;
	// sticky flag gated by enable
	assign irq = r.irq_flags[`PSP_BIT_IRQ] & r.irq_enable[`PSP_BIT_IRQ];
endmodule

// ### rtl/psp_host.sv
/*
 * external bus master end: turns a one-cycle command into a strobed
 * byte write or read of the slave port.
 * assumes the device samples strobes through two flops.
 */
`timescale 1ns/1ps
module psp_host #(
	parameter int STROBE_CYCLES = 8
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	psp_if.host pins,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_wdata,
	output logic busy,
	output logic done,
	output logic [7:0] rdata
);
	typedef struct packed {
		psp_pkg::psp_hs_e st;
		logic [7:0] cnt;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic done;
	} psp_host_s;

	psp_host_s r;
	psp_host_s next_r;

	// shorter strobes could slip between the device's two sampling flops
	if (STROBE_CYCLES < 4 || STROBE_CYCLES > 255) begin : g_bad_strobe
		$error("strobe length unsupported");
	end

	// ==========================================================
	// strobe sequencer; strobes held long enough to be sampled
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		case (r.st)
		psp_pkg::PSP_HS_IDLE: begin
			next_r.cnt = 8'h00;
			if (cmd_wr) begin
				next_r.st = psp_pkg::PSP_HS_WRITE;
				next_r.wdata = cmd_wdata;
			end else if (cmd_rd)
				next_r.st = psp_pkg::PSP_HS_READ;
		end
		psp_pkg::PSP_HS_WRITE, psp_pkg::PSP_HS_READ: begin
			next_r.cnt = r.cnt + 8'h01;
			if (r.cnt == 8'(STROBE_CYCLES - 1)) begin
				if (r.st == psp_pkg::PSP_HS_READ)
					next_r.rdata = pins.d_in;
				next_r.st = psp_pkg::PSP_HS_GAP;
				next_r.cnt = 8'h00;
			end
		end
		psp_pkg::PSP_HS_GAP: begin
			next_r.cnt = r.cnt + 8'h01;
			if (r.cnt == 8'(STROBE_CYCLES - 1)) begin
				next_r.st = psp_pkg::PSP_HS_IDLE;
				next_r.done = 1'b1;
			end
		end
		default: next_r.st = psp_pkg::PSP_HS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
			r.st <= psp_pkg::PSP_HS_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// pins: select low only during a strobe
	assign pins.cs_b = ~(r.st == psp_pkg::PSP_HS_WRITE ||
		r.st == psp_pkg::PSP_HS_READ);
	assign pins.wr_b = ~(r.st == psp_pkg::PSP_HS_WRITE);
	assign pins.rd_b = ~(r.st == psp_pkg::PSP_HS_READ);
	assign pins.host_d_out = r.wdata;
	assign pins.host_d_oe_b = ~(r.st == psp_pkg::PSP_HS_WRITE);
	assign busy = (r.st != psp_pkg::PSP_HS_IDLE);
	assign done = r.done;
	assign rdata = r.rdata;
endmodule

// ### test/psp_monitor.sv
/*
 * checker of the pin bundle that joins the host end and the device end.
 * assumes the bench instantiates it once, beside that bundle.
 */
`timescale 1ns/1ps
module psp_monitor (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic rd_b,
	input wire logic wr_b,
	input wire logic cs_b,
	input wire logic [7:0] host_d_out,
	input wire logic host_d_oe_b,
	input wire logic [7:0] dev_d_out,
	input wire logic dev_d_oe_b,
	input wire logic [7:0] d_in
);
	// ==========================================================
	// pin relations, all in the one clock domain
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	AST_NO_FIGHT: assert property (
		!(!dev_d_oe_b && !host_d_oe_b))
		else $error("both ends drive the data lines");
	AST_ONE_STROBE: assert property (
		rd_b || wr_b)
		else $error("read and write strobes low together");
	AST_CS_WITH_STROBE: assert property (
		!(rd_b && wr_b) |-> !cs_b)
		else $error("strobe low without chip select");
	AST_WR_LOW: assert property (
		$fell(wr_b) |-> !wr_b[*4])
		else $error("write strobe low too short");
	AST_RD_HIGH: assert property (
		$rose(rd_b) |-> rd_b[*4])
		else $error("read strobe high too short");
	AST_DRIVE_CAUSE: assert property (
		$fell(dev_d_oe_b) |-> !$past(rd_b) && !$past(cs_b))
		else $error("device drives without read");
	AST_DRIVE_END: assert property (
		$rose(rd_b) |-> ##[1:5] dev_d_oe_b)
		else $error("device keeps driving after read");
	AST_OUT_STEADY: assert property (
		!dev_d_oe_b && !$past(dev_d_oe_b) |-> $stable(dev_d_out))
		else $error("driven byte changed");
	AST_HOST_DRIVE: assert property (
		$fell(host_d_oe_b) |-> !wr_b && !cs_b)
		else $error("host drives outside write");
	// main scenarios seen at the pins
	cover property ($rose(wr_b));
	cover property ($rose(rd_b));
	cover property (!dev_d_oe_b);
endmodule

// ### test/parallel_slave_port_tb_top.sv
/*
 * bench joining host end and device end; firmware register calls and
 * host bus cycles with expected flag values.
 * assumes the data wire is resolved here from both enables.
 */
`timescale 1ns/1ps
module parallel_slave_port_tb_top;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, cmd_wr = 1'b0, cmd_rd = 1'b0;
	logic irq, busy, done;
	psp_pkg::psp_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, cmd_wdata = 8'h00;
	psp_pkg::psp_byte_t reg_rdata, rdata, pins_e, pat = 8'h5a;
	int fails = 0, tests_run = 0;
	// ==========================================================
	// clock, bundle and the two ends
	always #20 clk_sys = ~clk_sys;
	// released lines flip each cycle so a stale byte never matches
	always @(posedge clk_sys) pat <= ~pat;
	psp_if ifc();
	assign ifc.d_in = !ifc.dev_d_oe_b ? ifc.dev_d_out :
		(!ifc.host_d_oe_b ? ifc.host_d_out : pat);
	psp_device i_psp_device (.clk_sys(clk_sys), .rst_b(rst_b), .pins(ifc),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_e_pins_out(pins_e),
		.irq(irq));
	psp_host i_psp_host (.clk_sys(clk_sys), .rst_b(rst_b), .pins(ifc),
		.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
		.busy(busy), .done(done), .rdata(rdata));
	psp_monitor i_psp_monitor (.clk_sys(clk_sys), .rst_b(rst_b),
		.rd_b(ifc.rd_b), .wr_b(ifc.wr_b), .cs_b(ifc.cs_b),
		.host_d_out(ifc.host_d_out), .host_d_oe_b(ifc.host_d_oe_b),
		.dev_d_out(ifc.dev_d_out), .dev_d_oe_b(ifc.dev_d_oe_b),
		.d_in(ifc.d_in));
	// ==========================================================
	// tasks
	task automatic check(input string n, input psp_pkg::psp_byte_t seen,
		input psp_pkg::psp_byte_t exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wreg(input psp_pkg::psp_byte_t a, psp_pkg::psp_byte_t d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rreg(input psp_pkg::psp_byte_t a, psp_pkg::psp_byte_t e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 check("register", reg_rdata, e);
	endtask
	// flags land some cycles after strobe release, hence the tail wait
	task automatic host(input logic wr, input psp_pkg::psp_byte_t d);
		int i;
		@(posedge clk_sys);
		cmd_wr <= wr;
		cmd_rd <= !wr;
		cmd_wdata <= d;
		@(posedge clk_sys);
		cmd_wr <= 1'b0;
		cmd_rd <= 1'b0;
		for (i = 0; i < 200 && done !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		if (i == 200) begin
			fails++;
			end_of_test();
		end
		check("host busy", {7'h00, busy}, 8'h00);
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		rreg(8'h89, 8'h07);
		rreg(8'h0c, 8'h00);
		rreg(8'h8c, 8'h00);
		rreg(8'h9f, 8'h00);
		rreg(8'h88, 8'hff);
		wreg(8'h55, 8'hff);
		rreg(8'h55, 8'h00);
		host(1'b1, 8'h3c);
		rreg(8'h89, 8'h07);
		rreg(8'h0c, 8'h00);
		// slave mode with port d direction set all output
		wreg(8'h88, 8'h00);
		wreg(8'h9f, 8'h06);
		wreg(8'h8c, 8'h80);
		wreg(8'h89, 8'h17);
		rreg(8'h89, 8'h17);
		host(1'b1, 8'ha5);
		rreg(8'h89, 8'h97);
		rreg(8'h0c, 8'h80);
		check("irq", {7'h00, irq}, 8'h01);
		host(1'b1, 8'h5a);
		rreg(8'h89, 8'hb7);
		rreg(8'h08, 8'h5a);
		rreg(8'h89, 8'h37);
		wreg(8'h89, 8'h17);
		rreg(8'h89, 8'h17);
		wreg(8'h0c, 8'h00);
		wreg(8'h8c, 8'h00);
		rreg(8'h0c, 8'h00);
		wreg(8'h08, 8'hc3);
		rreg(8'h89, 8'h57);
		host(1'b0, 8'h00);
		check("host data", rdata, 8'hc3);
		rreg(8'h89, 8'h17);
		rreg(8'h0c, 8'h80);
		check("irq", {7'h00, irq}, 8'h00);
		// leave slave mode while output full would be set
		wreg(8'h08, 8'h96);
		wreg(8'h09, 8'h05);
		wreg(8'h89, 8'h02);
		rreg(8'h89, 8'h02);
		check("port e pins", {5'h00, pins_e[2:0]}, 8'h05);
		end_of_test();
	end
endmodule
